// *** shared/dtc_pkg.sv ***
// Purpose: Shared constants and types for the dual timer/counter unit
// Assumes: 8-bit special-function register port, one core clock
// Notes:   Offsets are byte addresses on the register port
package dtc_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
   localparam logic [7:0] ADDR_TIMER_MODE    = 8'h89;
   localparam logic [7:0] ADDR_T0_LOW        = 8'h8A;
   localparam logic [7:0] ADDR_T1_LOW        = 8'h8B;
   localparam logic [7:0] ADDR_T0_HIGH       = 8'h8C;
   localparam logic [7:0] ADDR_T1_HIGH       = 8'h8D;
   // Reset values
   localparam logic [7:0] RST_TIMER_CONTROL  = 8'h00;
   localparam logic [7:0] RST_TIMER_MODE     = 8'h00;
   localparam logic [7:0] RST_COUNT          = 8'h00;
   // Mode register fields
   localparam int MODE_T1_GATE   = 7;
   localparam int MODE_T1_SOURCE = 6;
   localparam int MODE_T1_SEL    = 4;
   localparam int MODE_T0_GATE   = 3;
   localparam int MODE_T0_SOURCE = 2;
   localparam int MODE_T0_SEL    = 0;
   // Control register fields
   localparam int CTRL_T1_FLAG = 7;
   localparam int CTRL_T1_RUN  = 6;
   localparam int CTRL_T0_FLAG = 5;
   localparam int CTRL_T0_RUN  = 4;
   // Prescaler width in mode 00
   localparam int PRESCALE_BITS = 5;

   typedef enum logic [1:0] {
      MODE_PRESCALED,
      MODE_CASCADE16,
      MODE_AUTORELOAD,
      MODE_SPLIT
   } dtc_mode_e;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } dtc_count_s;

   typedef struct packed {
      logic       write;
      logic [7:0] addr;
      logic [7:0] data;
   } dtc_write_s;
endpackage

// *** src/dtc_edge_sampler.sv ***
// Purpose: Synchronises one pin and flags a sampled falling edge
// Assumes: Pin level held at least one core clock period
// Notes:   Two sync stages, then a third sample for the edge compare
`timescale 1ns/100ps
`default_nettype none
module dtc_edge_sampler
   import dtc_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic resetSyncN,
   // Pin and result
   input  wire logic pinIn,
   output logic      pinLevel,
   output logic      fallPulse
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
   } dtc_sampler_s;

   dtc_sampler_s state_q;
   dtc_sampler_s state_d;

   always_comb begin
      state_d      = state_q;
      state_d.meta = pinIn;
      state_d.sync = state_q.meta;
      state_d.prev = state_q.sync;
   end

   always_ff @(posedge clock or negedge resetSyncN) begin
      if (!resetSyncN) begin
         state_q <= 3'b111;
      end else begin
         state_q <= state_d;
      end
   end

   assign pinLevel  = state_q.sync;
   assign fallPulse = state_q.prev & ~state_q.sync;

   AST_EDGE_SOURCE: assert property (@(posedge clock) disable iff (!resetSyncN)
      fallPulse |-> $past(pinIn, 3) && !$past(pinIn, 2))
      else $error("fall flagged without high then low samples");
endmodule
`default_nettype wire

// *** src/dtc_timer_unit.sv ***
// Purpose: Two timer/counters with mode and control registers
// Assumes: Register port writes one byte per cycle; reads are combinational
// Notes:   Overflow flags clear on the interrupt acknowledge inputs
//
// Function
// - Timer function adds one to the low byte every core clock.
// - Counter function counts sampled high-then-low transitions on the count pin.
// - Recognising one falling edge takes two cycles; top rate is half clock.
// - Each timer has high and low bytes, separate or joined per mode.
// - Mode bit 7 gates timer 1 with its interrupt pin and run bit.
// - Mode bit 3 gates timer 0 with its interrupt pin and run bit.
// - Mode bit 6 picks timer 1 source: count pin edges or clock.
// - Mode bit 2 picks timer 0 source: count pin edges or clock.
// - Mode 00: high byte counts, low five bits prescale.
// - Mode 01: high and low bytes form one 16-bit counter.
// - Mode 10: low byte counts, reloads from high byte on overflow.
// - Mode 11 stops timer 1, holding its bytes.
// - Timer 0 mode 11: low byte counts under timer 0 controls.
// - Timer 0 mode 11: high byte counts clocks under timer 1 run/flag.
// - Timers count only while their run bit is set, except the timer 0 high byte in mode 11, which runs on the timer 1 run bit.
// - Overflow sets the flag, except timer 1 overflow while timer 0 is in mode 11; interrupt vectoring clears it.
`timescale 1ns/100ps
`default_nettype none
module dtc_timer_unit
   import dtc_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // Register port
   input  wire dtc_write_s regWrite,
   input  wire logic [7:0] regReadAddr,
   output logic [7:0]      regReadData,
   // Pins
   input  wire logic       timer0CountPin,
   input  wire logic       timer1CountPin,
   input  wire logic       extIrq0Pin,
   input  wire logic       extIrq1Pin,
   // Interrupt vectoring
   input  wire logic       timer0Vector,
   input  wire logic       timer1Vector,
   output logic            timer0Overflow,
   output logic            timer1Overflow
);
   typedef struct packed {
      logic [7:0]  mode;
      logic [7:0]  control;
      dtc_count_s  t0;
      dtc_count_s  t1;
   } dtc_unit_s;

   dtc_unit_s state_q;
   dtc_unit_s state_d;
   logic [1:0] resetSync_q;
   logic      resetSyncN;
   logic      t0Fall;
   logic      t1Fall;
   logic      irq0Level;
   logic      irq1Level;

   ////////////////////////////////////////////////////////////////////
   // Reset release
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         resetSync_q <= 2'b00;
      end else begin
         resetSync_q <= {resetSync_q[0], 1'b1};
      end
   end
   assign resetSyncN = resetSync_q[1];

   ////////////////////////////////////////////////////////////////////
   // Pin sampling
   // sync plus compare
   dtc_edge_sampler u_t0_pin (.clock(clock), .resetSyncN(resetSyncN), .pinIn(timer0CountPin),
                              .pinLevel(), .fallPulse(t0Fall));
   dtc_edge_sampler u_t1_pin (.clock(clock), .resetSyncN(resetSyncN), .pinIn(timer1CountPin),
                              .pinLevel(), .fallPulse(t1Fall));
   dtc_edge_sampler u_irq0_pin (.clock(clock), .resetSyncN(resetSyncN), .pinIn(extIrq0Pin),
                                .pinLevel(irq0Level), .fallPulse());
   dtc_edge_sampler u_irq1_pin (.clock(clock), .resetSyncN(resetSyncN), .pinIn(extIrq1Pin),
                                .pinLevel(irq1Level), .fallPulse());

   ////////////////////////////////////////////////////////////////////
   // Count logic
   dtc_mode_e  mode0;
   dtc_mode_e  mode1;
   logic       tick0;
   logic       tick1;
   logic       tickSplit;
   logic       ovf0;
   logic       ovf1;
   logic       ovfSplit;
   logic [8:0] low0Sum;
   logic [8:0] high0Sum;
   logic [8:0] low1Sum;
   logic [8:0] high1Sum;

   always_comb begin
      mode0 = dtc_mode_e'(state_q.mode[MODE_T0_SEL +: 2]);
      mode1 = dtc_mode_e'(state_q.mode[MODE_T1_SEL +: 2]);
      tick0 = state_q.control[CTRL_T0_RUN]
            & (~state_q.mode[MODE_T0_GATE] | irq0Level)
            & (state_q.mode[MODE_T0_SOURCE] ? t0Fall : 1'b1);
      tick1 = state_q.control[CTRL_T1_RUN]
            & (~state_q.mode[MODE_T1_GATE] | irq1Level)
            & (state_q.mode[MODE_T1_SOURCE] ? t1Fall : 1'b1);
      tickSplit = state_q.control[CTRL_T1_RUN];
   end

   always_comb begin
      state_d  = state_q;
      ovf0     = 1'b0;
      ovf1     = 1'b0;
      ovfSplit = 1'b0;
      low0Sum  = {1'b0, state_q.t0.low} + 9'h001;
      high0Sum = {1'b0, state_q.t0.high} + 9'h001;
      low1Sum  = {1'b0, state_q.t1.low} + 9'h001;
      high1Sum = {1'b0, state_q.t1.high} + 9'h001;

      if (tick0) begin
         case (mode0)
            MODE_PRESCALED: begin
               state_d.t0.low = {3'b000, low0Sum[PRESCALE_BITS-1:0]};
               if (low0Sum[PRESCALE_BITS]) begin
                  state_d.t0.high = high0Sum[7:0];
                  ovf0            = high0Sum[8];
               end
            end
            MODE_CASCADE16: begin
               state_d.t0.low = low0Sum[7:0];
               if (low0Sum[8]) begin
                  state_d.t0.high = high0Sum[7:0];
                  ovf0            = high0Sum[8];
               end
            end
            MODE_AUTORELOAD: begin
               state_d.t0.low = low0Sum[8] ? state_q.t0.high : low0Sum[7:0];
               ovf0           = low0Sum[8];
            end
            MODE_SPLIT: begin
               state_d.t0.low = low0Sum[7:0];
               ovf0           = low0Sum[8];
            end
            default: ovf0 = 1'b0;
         endcase
      end

      if (mode0 == MODE_SPLIT && tickSplit) begin
         state_d.t0.high = high0Sum[7:0];
         ovfSplit        = high0Sum[8];
      end

      if (tick1) begin
         case (mode1)
            MODE_PRESCALED: begin
               state_d.t1.low = {3'b000, low1Sum[PRESCALE_BITS-1:0]};
               if (low1Sum[PRESCALE_BITS]) begin
                  state_d.t1.high = high1Sum[7:0];
                  ovf1            = high1Sum[8];
               end
            end
            MODE_CASCADE16: begin
               state_d.t1.low = low1Sum[7:0];
               if (low1Sum[8]) begin
                  state_d.t1.high = high1Sum[7:0];
                  ovf1            = high1Sum[8];
               end
            end
            MODE_AUTORELOAD: begin
               state_d.t1.low = low1Sum[8] ? state_q.t1.high : low1Sum[7:0];
               ovf1           = low1Sum[8];
            end
            MODE_SPLIT: begin
               ovf1 = 1'b0;
            end
            default: ovf1 = 1'b0;
         endcase
      end

      // Software writes, counting loses to them
      if (regWrite.write) begin
         case (regWrite.addr)
            ADDR_TIMER_MODE:    state_d.mode    = regWrite.data;
            ADDR_TIMER_CONTROL: state_d.control = regWrite.data;
            ADDR_T0_LOW:        state_d.t0.low  = regWrite.data;
            ADDR_T0_HIGH:       state_d.t0.high = regWrite.data;
            ADDR_T1_LOW:        state_d.t1.low  = regWrite.data;
            ADDR_T1_HIGH:       state_d.t1.high = regWrite.data;
            default:            state_d.mode    = state_q.mode;
         endcase
      end

      if (timer0Vector) begin
         state_d.control[CTRL_T0_FLAG] = 1'b0;
      end
      if (timer1Vector) begin
         state_d.control[CTRL_T1_FLAG] = 1'b0;
      end
      if (ovf0) begin
         state_d.control[CTRL_T0_FLAG] = 1'b1;
      end
      if ((ovf1 && mode0 != MODE_SPLIT) || ovfSplit) begin
         state_d.control[CTRL_T1_FLAG] = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge resetSyncN) begin
      if (!resetSyncN) begin
         state_q.mode    <= RST_TIMER_MODE;
         state_q.control <= RST_TIMER_CONTROL;
         state_q.t0      <= {RST_COUNT, RST_COUNT};
         state_q.t1      <= {RST_COUNT, RST_COUNT};
      end else begin
         state_q.mode    <= state_d.mode;
         state_q.control <= state_d.control;
         state_q.t0      <= state_d.t0;
         state_q.t1      <= state_d.t1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read side
   always_comb begin
      case (regReadAddr)
         ADDR_TIMER_MODE:    regReadData = state_q.mode;
         ADDR_TIMER_CONTROL: regReadData = state_q.control;
         ADDR_T0_LOW:        regReadData = state_q.t0.low;
         ADDR_T0_HIGH:       regReadData = state_q.t0.high;
         ADDR_T1_LOW:        regReadData = state_q.t1.low;
         ADDR_T1_HIGH:       regReadData = state_q.t1.high;
         default:            regReadData = 8'h00;
      endcase
   end

   assign timer0Overflow = state_q.control[CTRL_T0_FLAG];
   assign timer1Overflow = state_q.control[CTRL_T1_FLAG];

   ////////////////////////////////////////////////////////////////////
   // Checks
   AST_T0_TIMER_STEP: assert property (@(posedge clock) disable iff (!resetSyncN)
      (tick0 && mode0 == MODE_CASCADE16 && !state_q.mode[MODE_T0_SOURCE]
       && !regWrite.write)
      |=> state_q.t0.low == $past(state_q.t0.low) + 8'h01)
      else $error("timer 0 low byte did not step");
   AST_T0_PIN_EDGE: assert property (@(posedge clock) disable iff (!resetSyncN)
      (state_q.mode[MODE_T0_SOURCE] && tick0) |-> t0Fall)
      else $error("timer 0 counted without pin edge");
   AST_EDGE_SPACING: assert property (@(posedge clock) disable iff (!resetSyncN)
      t0Fall |=> !t0Fall)
      else $error("two edges in back to back cycles");
   AST_T1_GATE: assert property (@(posedge clock) disable iff (!resetSyncN)
      (state_q.mode[MODE_T1_GATE] && !irq1Level) |-> !tick1)
      else $error("timer 1 counted with gate low");
   AST_T0_GATE: assert property (@(posedge clock) disable iff (!resetSyncN)
      (state_q.mode[MODE_T0_GATE] && !irq0Level) |-> !tick0)
      else $error("timer 0 counted with gate low");
   AST_PRESCALE: assert property (@(posedge clock) disable iff (!resetSyncN)
      (tick0 && mode0 == MODE_PRESCALED && !regWrite.write)
      |=> state_q.t0.low[7:5] == 3'b000)
      else $error("prescaler wider than five bits");
   AST_RELOAD: assert property (@(posedge clock) disable iff (!resetSyncN)
      (tick0 && mode0 == MODE_AUTORELOAD && state_q.t0.low == 8'hFF && !regWrite.write)
      |=> state_q.t0.low == $past(state_q.t0.high))
      else $error("autoreload value wrong");
   AST_T1_HOLD: assert property (@(posedge clock) disable iff (!resetSyncN)
      (mode1 == MODE_SPLIT && !regWrite.write) |=> $stable(state_q.t1))
      else $error("timer 1 moved in mode 11");
   AST_RUN_OFF: assert property (@(posedge clock) disable iff (!resetSyncN)
      (!state_q.control[CTRL_T0_RUN] && !regWrite.write) |=> $stable(state_q.t0.low))
      else $error("timer 0 moved with run clear");
   AST_FLAG_SET: assert property (@(posedge clock) disable iff (!resetSyncN)
      ovf0 |=> timer0Overflow)
      else $error("timer 0 overflow flag not set");
   AST_SPLIT_FLAG: assert property (@(posedge clock) disable iff (!resetSyncN)
      (mode0 == MODE_SPLIT && !ovfSplit && !timer1Overflow && !regWrite.write)
      |=> !timer1Overflow)
      else $error("timer 1 set its flag in split mode");
endmodule
`default_nettype wire

// *** sim/dtc_pin_model.sv ***
// Purpose: Far-side model of the count and gate pins
// Assumes: Called from the bench at a falling clock edge
// Notes:   Idle level high, as the pins have pull-ups
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_model (
   // Clock
   input  wire logic clock,
   // Pins
   output var logic  countPin0,
   output var logic  countPin1,
   output var logic  gatePin0,
   output var logic  gatePin1
);
   initial begin
      countPin0 = 1'b1;
      countPin1 = 1'b1;
      gatePin0  = 1'b1;
      gatePin1  = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // level hold
   // Each level held h whole cycles, h at least one
   task automatic pulses(input int ch, input int n, input int h);
      repeat (n) begin
         if (ch == 0) countPin0 = 1'b0; else countPin1 = 1'b0;
         repeat (h) @(negedge clock);
         if (ch == 0) countPin0 = 1'b1; else countPin1 = 1'b1;
         repeat (h) @(negedge clock);
      end
   endtask

   task automatic gate(input int ch, input logic v);
      if (ch == 0) gatePin0 = v; else gatePin1 = v;
   endtask
endmodule
`default_nettype wire

// *** sim/dual_timer_counter_unit_test.sv ***
// Purpose: Self-checking bench for the dual timer/counter unit
// Assumes: Inputs driven at the falling edge; reads are combinational
// Notes:   Run and stop writes bracket exact count windows
`timescale 1ns/100ps
`default_nettype none
module dual_timer_counter_unit_test;
   import dtc_pkg::*;

   logic       clock;
   logic       reset_n;
   dtc_write_s regWrite;
   logic [7:0] regReadAddr;
   logic [7:0] regReadData;
   logic       pin0, pin1, gate0, gate1;
   logic       vec0, vec1, ovf0, ovf1;
   int         fail_count;
   int         comparisons;
   logic [7:0] modeTab [2];
   logic [7:0] runTab [2];
   logic [7:0] lowTab [2];

   dtc_timer_unit DUT (
      .clock(clock), .reset_n(reset_n), .regWrite(regWrite), .regReadAddr(regReadAddr),
      .regReadData(regReadData), .timer0CountPin(pin0), .timer1CountPin(pin1),
      .extIrq0Pin(gate0), .extIrq1Pin(gate1), .timer0Vector(vec0), .timer1Vector(vec1),
      .timer0Overflow(ovf0), .timer1Overflow(ovf1));

   dtc_pin_model pins (
      .clock(clock), .countPin0(pin0), .countPin1(pin1), .gatePin0(gate0), .gatePin1(gate1));

   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("Mismatches %0d of %0d comparisons", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t byte got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t bit got %b exp %b", $time, got, exp);
      end
   endtask

   // Write held across one rising edge; back to back keeps strobe up
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regWrite = '{1'b1, a, d};
      @(negedge clock);
   endtask

   task automatic idle(input int n);
      regWrite.write = 1'b0;
      repeat (n) @(negedge clock);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      regReadAddr = a;
      #1;
      chk8(regReadData, exp);
      @(negedge clock);
   endtask

   // Exactly one counting edge
   task automatic once(input logic [7:0] run);
      wr(ADDR_TIMER_CONTROL, run);
      wr(ADDR_TIMER_CONTROL, 8'h00);
      idle(3);
   endtask

   task automatic vector(input int ch);
      if (ch == 0) vec0 = 1'b1; else vec1 = 1'b1;
      @(negedge clock);
      vec0 = 1'b0;
      vec1 = 1'b0;
      idle(2);
      rd(ADDR_TIMER_CONTROL, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   initial begin
      #500us;
      fail_count++;
      $display("ERROR t=%0t run did not finish in time", $time);
      give_verdict();
   end

   initial begin
      reset_n = 1'b0;
      regWrite = '0;
      regReadAddr = 8'h00;
      vec0 = 1'b0;
      vec1 = 1'b0;
      fail_count = 0;
      comparisons = 0;
      modeTab = '{8'h09, 8'h90};
      runTab = '{8'h10, 8'h40};
      lowTab = '{ADDR_T0_LOW, ADDR_T1_LOW};
      repeat (3) @(negedge clock);
      reset_n = 1'b1;
      idle(3);
      for (int a = 8'h88; a <= 8'h8D; a++) rd(8'(a), 8'h00);
      wr(8'h90, 8'hFF);
      wr(ADDR_TIMER_MODE, 8'hA5);
      wr(ADDR_TIMER_CONTROL, 8'h0F);
      idle(1);
      rd(8'h90, 8'h00);
      rd(ADDR_TIMER_MODE, 8'hA5);
      rd(ADDR_TIMER_CONTROL, 8'h0F);
      wr(ADDR_TIMER_MODE, 8'h01);
      wr(ADDR_TIMER_CONTROL, 8'h10);
      idle(9);
      wr(ADDR_TIMER_CONTROL, 8'h00);
      idle(6);
      rd(ADDR_T0_LOW, 8'h0A);
      // Prescaled mode wraps the low five bits into the high byte
      wr(ADDR_TIMER_MODE, 8'h00);
      wr(ADDR_T0_LOW, 8'h1F);
      wr(ADDR_T0_HIGH, 8'h05);
      once(8'h10);
      rd(ADDR_T0_HIGH, 8'h06);
      rd(ADDR_T0_LOW, 8'h00);
      // Full 16-bit wrap sets the flag
      wr(ADDR_TIMER_MODE, 8'h01);
      wr(ADDR_T0_LOW, 8'hFF);
      wr(ADDR_T0_HIGH, 8'hFF);
      once(8'h10);
      rd(ADDR_T0_HIGH, 8'h00);
      rd(ADDR_T0_LOW, 8'h00);
      chk1(ovf0, 1'b1);
      rd(ADDR_TIMER_CONTROL, 8'h20);
      vector(0);
      wr(ADDR_TIMER_MODE, 8'h20);
      wr(ADDR_T1_LOW, 8'hFF);
      wr(ADDR_T1_HIGH, 8'h33);
      once(8'h40);
      rd(ADDR_T1_LOW, 8'h33);
      chk1(ovf1, 1'b1);
      vector(1);
      wr(ADDR_TIMER_MODE, 8'h30);
      wr(ADDR_T1_LOW, 8'h07);
      wr(ADDR_TIMER_CONTROL, 8'h40);
      idle(10);
      rd(ADDR_T1_LOW, 8'h07);
      wr(ADDR_TIMER_CONTROL, 8'h00);
      // Split: timer 0 high byte runs on the timer 1 run bit
      wr(ADDR_TIMER_MODE, 8'h13);
      wr(ADDR_T0_HIGH, 8'hFF);
      wr(ADDR_T0_LOW, 8'h00);
      wr(ADDR_T1_LOW, 8'h00);
      wr(ADDR_T1_HIGH, 8'h00);
      once(8'h40);
      rd(ADDR_T0_HIGH, 8'h00);
      rd(ADDR_T0_LOW, 8'h00);
      rd(ADDR_T1_LOW, 8'h01);
      rd(ADDR_TIMER_CONTROL, 8'h80);
      vector(1);
      wr(ADDR_T0_HIGH, 8'h10);
      wr(ADDR_T1_LOW, 8'hFF);
      wr(ADDR_T1_HIGH, 8'hFF);
      once(8'h40);
      rd(ADDR_T1_HIGH, 8'h00);
      rd(ADDR_TIMER_CONTROL, 8'h00);
      once(8'h10);
      rd(ADDR_T0_LOW, 8'h01);
      // Gate low blocks counting, gate high allows it
      for (int t = 0; t < 2; t++) begin
         wr(ADDR_TIMER_MODE, modeTab[t]);
         wr(lowTab[t], 8'h00);
         idle(1);
         pins.gate(t, 1'b0);
         idle(3);
         wr(ADDR_TIMER_CONTROL, runTab[t]);
         idle(10);
         wr(ADDR_TIMER_CONTROL, 8'h00);
         idle(1);
         rd(lowTab[t], 8'h00);
         pins.gate(t, 1'b1);
         idle(3);
         wr(ADDR_TIMER_CONTROL, runTab[t]);
         idle(9);
         wr(ADDR_TIMER_CONTROL, 8'h00);
         idle(1);
         rd(lowTab[t], 8'h0A);
      end
      // Counter function: pin edges, not clocks, at top and slow rates
      for (int t = 0; t < 2; t++) begin
         wr(ADDR_TIMER_MODE, t == 0 ? 8'h05 : 8'h50);
         wr(lowTab[t], 8'h00);
         wr(ADDR_TIMER_CONTROL, runTab[t]);
         idle(1);
         pins.pulses(t, 5, t + 1);
         idle(8);
         rd(lowTab[t], 8'h05);
         wr(ADDR_TIMER_CONTROL, 8'h00);
         idle(1);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
